// ---- smcp_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// serial host
// ****
module smcp_host_model (
    input wire logic clk,
    input wire logic sdo_line,
    output logic cs_n = 1'b1,
    output logic sck = 1'b0,
    output logic sdi = 1'b0
);
    // n rising edges; edges past 16 carry inverted filler
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge clk) cs_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            sdi <= (k < 16) ? w[15 - k] : ~w[0];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            if (k >= 8 && k < 16) rd[15 - k] = sdo_line;
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        sdi <= ~sdi;
        repeat (16) @(posedge clk);
    endtask : xfer
endmodule : smcp_host_model
`default_nettype wire

// ---- smcp_pkg.sv ----
package smcp_pkg;

    typedef enum logic [1:0] {
        SMCP_PD_NORMAL = 2'h0,
        SMCP_PD_CH2_NAP = 2'h1,
        SMCP_PD_BOTH_NAP = 2'h2,
        SMCP_PD_SLEEP = 2'h3
    } smcp_pd_e;

    typedef enum logic [1:0] {
        SMCP_IDLE = 2'h0,
        SMCP_SHIFT = 2'h1,
        SMCP_DONE = 2'h3
    } smcp_state_e;

    typedef struct packed {
        logic outclk_invert;
        logic [1:0] outclk_phase_delay;
        logic duty_cycle_stabilizer_en;
    } smcp_timing_s;

    typedef struct packed {
        logic ch1_nap;
        logic ch2_nap;
        logic sleep;
        logic ch1_valid;
        logic ch2_valid;
    } smcp_power_s;

endpackage : smcp_pkg

// ---- smcp_regs.svh ----
`ifndef SMCP_REGS_SVH
`define SMCP_REGS_SVH

`define SMCP_ADDR_SOFT_RESET 7'h00
`define SMCP_ADDR_POWER_DOWN 7'h01
`define SMCP_ADDR_CLK_TIMING 7'h02
`define SMCP_RESET_VALUE 8'h00
`define SMCP_SOFT_RESET_BIT 7
`define SMCP_WORD_BITS 5'h10
`define SMCP_DATA_START 5'h08
`define SMCP_PD_LSB 0
`define SMCP_PD_MSB 1
`define SMCP_DCS_BIT 0
`define SMCP_PHASE_LSB 1
`define SMCP_PHASE_MSB 2
`define SMCP_INV_BIT 3
`define SMCP_PD_MASK 8'h03
`define SMCP_TIMING_MASK 8'h0f
`define SMCP_SLEEP_PULSE_CYCLES 4'h8
`define SMCP_NAP_WAKE_SAMPLE_CYCLES 8'h64

`endif

// ---- smcp_serial_port.sv ----
// Overview of operation
// R01 - host holds interface_select low to use the serial port
// R02 - falling chip select starts a new command word
// R03 - serial input sampled on first 16 rising serial-clock edges
// R04 - rising edges after the sixteenth ignored until chip select rises
// R05 - rising chip select closes the current command
// R06 - word is read/write flag, address A6:A0, then data D7:D0
// R07 - flag 0 writes eight data bits to addressed register; code keeps only bits 1:0 of power-down and bits 3:0 of timing
// R08 - flag 1 returns addressed register on serial output
// R09 - read-back leaves register unchanged and ignores serial input
// R10 - serial output is open drain, only pulls low
// R11 - host's first command after power-up is a software reset
// R12 - writing 1 to reset bit clears every mode register
// R13 - software reset briefly forces full sleep
// R14 - reset bit clears itself once the write completes
// R15 - reset register is write-only, read-back undefined
// R16 - power-down field: normal, ch2 nap, both nap, sleep
// R17 - timing bit 3 inverts output sample clock
// R18 - phase field delays output sample clock 0/45/90/135 degrees
// R19 - host enables stabilizer whenever phase delay is non-zero
// R20 - timing bit 0 enables duty cycle stabilizer
// R21 - channel 1 never naps while channel 2 runs
// R22 - nap wake needs 100 sample clocks; sleep powers all down
// R23 - read data driven msb first over final eight clocks
`timescale 1ns/1ns
`default_nettype none
`include "smcp_regs.svh"

module smcp_serial_port (
    input wire logic clk,
    input wire logic resetn,
    input wire logic interface_select,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic sdi,
    input wire logic sdo_in,
    output logic sdo_out,
    output logic sdo_oe_n,
    input wire logic sample_clk,
    output var smcp_pkg::smcp_power_s power_state,
    output var smcp_pkg::smcp_timing_s clock_timing,
    output logic [1:0] power_down_field,
    output logic output_sample_clock,
    output logic soft_reset_active
);

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] sel_sync;
    logic [1:0] cs_sync;
    logic [1:0] sck_sync;
    logic [1:0] sdi_sync;
    logic [1:0] smp_sync;
    logic cs_q;
    logic sck_q;
    logic smp_q;

    always_ff @(posedge clk) begin
        sel_sync <= {sel_sync[0], interface_select};
        cs_sync <= {cs_sync[0], cs_n};
        sck_sync <= {sck_sync[0], sck};
        sdi_sync <= {sdi_sync[0], sdi};
        smp_sync <= {smp_sync[0], sample_clk};
    end

    // previous synchronised levels for edge finding
    always_ff @(posedge clk) begin
        cs_q <= cs_sync[1];
        sck_q <= sck_sync[1];
        smp_q <= smp_sync[1];
    end

    wire serial_mode = ~sel_sync[1]; // R01
    wire cs_fall = cs_q & ~cs_sync[1]; // R02
    wire cs_rise = ~cs_q & cs_sync[1]; // R05
    wire sck_rise = ~sck_q & sck_sync[1];
    wire sck_fall = sck_q & ~sck_sync[1];
    wire smp_rise = ~smp_q & smp_sync[1];
    wire smp_fall = smp_q & ~smp_sync[1];

    // ****************************************
    // word capture
    // ****************************************
    smcp_pkg::smcp_state_e state;
    smcp_pkg::smcp_state_e next_state;
    logic [4:0] bit_cnt;
    logic [15:0] shift;
    logic [7:0] rd_data;
    logic [7:0] power_down_ctrl;
    logic [7:0] output_clock_timing;

    wire take_bit = (state == smcp_pkg::SMCP_SHIFT) & sck_rise & ~cs_sync[1]; // R03
    wire last_bit = take_bit & (bit_cnt == `SMCP_WORD_BITS - 5'h01);
    wire [15:0] next_shift = {shift[14:0], sdi_sync[1]}; // R06
    wire wr_flag = shift[15];
    wire [6:0] wr_addr = shift[14:8];
    wire [7:0] wr_data = shift[7:0];
    wire [6:0] rd_addr = {shift[5:0], sdi_sync[1]};
    wire is_read_hdr = take_bit & (bit_cnt == `SMCP_DATA_START - 5'h01) & shift[6];
    wire word_write = cs_rise & (state == smcp_pkg::SMCP_DONE) & ~wr_flag; // R07 R09 R05

    always_comb begin
        next_state = state;
        case (state)
            smcp_pkg::SMCP_IDLE: begin
                if (cs_fall && serial_mode) begin
                    next_state = smcp_pkg::SMCP_SHIFT; // R02
                end
            end
            smcp_pkg::SMCP_SHIFT: begin
                if (cs_rise) begin
                    next_state = smcp_pkg::SMCP_IDLE;
                end else if (last_bit) begin
                    next_state = smcp_pkg::SMCP_DONE;
                end
            end
            smcp_pkg::SMCP_DONE: begin
                if (cs_rise) begin
                    next_state = smcp_pkg::SMCP_IDLE; // R04
                end
            end
            default: begin
                next_state = smcp_pkg::SMCP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state <= smcp_pkg::SMCP_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn || cs_fall) begin
            bit_cnt <= 5'h00;
            shift <= 16'h0000;
        end else if (take_bit) begin
            bit_cnt <= bit_cnt + 5'h01; // R03
            shift <= next_shift;
        end
    end

    // ****************************************
    // read-back
    // ****************************************
    wire [7:0] rd_mux = (rd_addr == `SMCP_ADDR_POWER_DOWN) ? power_down_ctrl :
                        (rd_addr == `SMCP_ADDR_CLK_TIMING) ? output_clock_timing :
                        8'h00; // R15
    wire rd_active = (state != smcp_pkg::SMCP_IDLE) & ~cs_sync[1];
    logic rd_mode;

    always_ff @(posedge clk) begin
        if (!resetn || cs_fall) begin
            rd_mode <= 1'b0;
            rd_data <= 8'h00;
        end else if (is_read_hdr) begin
            rd_mode <= 1'b1; // R08
            rd_data <= rd_mux;
        end else if (rd_mode && sck_fall && rd_active && bit_cnt > `SMCP_DATA_START) begin
            rd_data <= {rd_data[6:0], 1'b1}; // R23
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sdo_out <= 1'b0;
            sdo_oe_n <= 1'b1;
        end else begin
            sdo_out <= 1'b0; // R10
            sdo_oe_n <= ~(rd_mode & rd_active & ~rd_data[7]); // R10 R23
        end
    end

    // ****************************************
    // mode registers and soft reset
    // ****************************************
    wire soft_reset = word_write & (wr_addr == `SMCP_ADDR_SOFT_RESET)
                      & wr_data[`SMCP_SOFT_RESET_BIT]; // R12 R14
    logic [3:0] sleep_cnt;

    always_ff @(posedge clk) begin
        if (!resetn || soft_reset) begin
            power_down_ctrl <= `SMCP_RESET_VALUE; // R12
            output_clock_timing <= `SMCP_RESET_VALUE;
        end else if (word_write && wr_addr == `SMCP_ADDR_POWER_DOWN) begin
            power_down_ctrl <= wr_data & `SMCP_PD_MASK; // R07 R16
        end else if (word_write && wr_addr == `SMCP_ADDR_CLK_TIMING) begin
            output_clock_timing <= wr_data & `SMCP_TIMING_MASK; // R07
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sleep_cnt <= 4'h0;
        end else if (soft_reset) begin
            sleep_cnt <= `SMCP_SLEEP_PULSE_CYCLES; // R13
        end else if (sleep_cnt != 4'h0) begin
            sleep_cnt <= sleep_cnt - 4'h1;
        end
    end

    assign soft_reset_active = (sleep_cnt != 4'h0);

    // ****************************************
    // power state
    // ****************************************
    wire [1:0] pd_eff = soft_reset_active ? smcp_pkg::SMCP_PD_SLEEP
                        : power_down_ctrl[`SMCP_PD_MSB:`SMCP_PD_LSB]; // R13
    wire ch2_nap = (pd_eff == smcp_pkg::SMCP_PD_CH2_NAP) | (pd_eff == smcp_pkg::SMCP_PD_BOTH_NAP);
    wire ch1_nap = (pd_eff == smcp_pkg::SMCP_PD_BOTH_NAP); // R21
    wire sleep_now = (pd_eff == smcp_pkg::SMCP_PD_SLEEP); // R22
    logic [7:0] wake1_cnt;
    logic [7:0] wake2_cnt;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wake1_cnt <= 8'h00;
            wake2_cnt <= 8'h00;
        end else begin
            if (ch1_nap || sleep_now) begin
                wake1_cnt <= `SMCP_NAP_WAKE_SAMPLE_CYCLES; // R22
            end else if (smp_rise && wake1_cnt != 8'h00) begin
                wake1_cnt <= wake1_cnt - 8'h01;
            end
            if (ch2_nap || sleep_now) begin
                wake2_cnt <= `SMCP_NAP_WAKE_SAMPLE_CYCLES;
            end else if (smp_rise && wake2_cnt != 8'h00) begin
                wake2_cnt <= wake2_cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            power_state <= '0;
            power_down_field <= 2'h0;
        end else begin
            power_state.ch1_nap <= ch1_nap;
            power_state.ch2_nap <= ch2_nap;
            power_state.sleep <= sleep_now;
            power_state.ch1_valid <= ~ch1_nap & ~sleep_now & (wake1_cnt == 8'h00);
            power_state.ch2_valid <= ~ch2_nap & ~sleep_now & (wake2_cnt == 8'h00);
            power_down_field <= pd_eff; // R16
        end
    end

    // ****************************************
    // output sample clock
    // ****************************************
    logic [3:0] ph_cnt;
    logic [3:0] half_len;
    logic [3:0] delay_cnt;
    logic outclk_raw;

    wire smp_edge = smp_rise | smp_fall;
    wire [3:0] next_half_len = (ph_cnt == 4'hf) ? 4'hf : ph_cnt + 4'h1;
    // eighths of a period are quarters of the measured half period
    wire [7:0] delay_prod = {4'h0, half_len} * {6'h00, clock_timing.outclk_phase_delay}; // R18
    wire [3:0] next_delay = delay_prod[5:2];
    wire outclk_follow = (delay_cnt == 4'h0);

    // half period measured in clk cycles
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ph_cnt <= 4'h0;
            half_len <= 4'h1;
        end else if (smp_edge) begin
            ph_cnt <= 4'h0;
            half_len <= next_half_len;
        end else if (ph_cnt != 4'hf) begin
            ph_cnt <= ph_cnt + 4'h1;
        end
    end

    // old level held until the phase delay has run out
    always_ff @(posedge clk) begin
        if (!resetn) begin
            delay_cnt <= 4'h0;
            outclk_raw <= 1'b0;
        end else begin
            if (smp_edge) begin
                delay_cnt <= next_delay; // R18
            end else if (delay_cnt != 4'h0) begin
                delay_cnt <= delay_cnt - 4'h1;
            end
            if (outclk_follow) begin
                outclk_raw <= smp_q;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            clock_timing <= '0;
            output_sample_clock <= 1'b0;
        end else begin
            clock_timing <= output_clock_timing[`SMCP_INV_BIT:`SMCP_DCS_BIT]; // R17 R18 R20
            output_sample_clock <= outclk_raw ^ clock_timing.outclk_invert; // R17
        end
    end

endmodule : smcp_serial_port
`default_nettype wire

// ---- smcp_serial_port_assertions.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// protocol checks
// ****
module smcp_serial_port_assertions (
    input wire logic clk,
    input wire logic resetn,
    input wire logic cs_n,
    input wire logic sdo_out,
    input wire logic sdo_oe_n,
    input wire smcp_pkg::smcp_power_s power_state,
    input wire smcp_pkg::smcp_timing_s clock_timing,
    input wire logic [1:0] power_down_field,
    input wire logic soft_reset_active
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    a_sdo_only_low: assert property (sdo_out == 1'b0)
        else $error("sdo driven high");
    a_oe_idle_release: assert property (cs_n [*8] |-> sdo_oe_n)
        else $error("sdo held low outside frame");
    a_timing_hold_idle: assert property (cs_n [*8] ##1 cs_n [*4] |-> $stable(clock_timing))
        else $error("timing changed outside frame");
    a_pulse_width: assert property ($rose(soft_reset_active) |->
        soft_reset_active [*8] ##1 !soft_reset_active)
        else $error("soft reset pulse length wrong");
    a_reset_sleeps: assert property (soft_reset_active |-> ##[0:2] power_down_field == 2'h3)
        else $error("no sleep during soft reset");
    a_reset_clears: assert property ($fell(soft_reset_active) |->
        ##[0:2] (power_down_field == 2'h0 && clock_timing == 4'h0))
        else $error("registers not cleared");
    a_no_ch1_alone: assert property (!(power_state.ch1_nap && !power_state.ch2_nap))
        else $error("channel 1 naps alone");
    a_sleep_follows: assert property (power_down_field == 2'h3 |-> ##[0:3] power_state.sleep)
        else $error("sleep not entered");
    a_nap_follows: assert property (power_down_field == 2'h2 |->
        ##[0:3] (power_state.ch1_nap && power_state.ch2_nap))
        else $error("both nap not entered");
    cover property ($rose(soft_reset_active));
    cover property (!sdo_oe_n);
    cover property (power_state.ch2_nap && !power_state.ch1_nap);
endmodule : smcp_serial_port_assertions
bind smcp_serial_port smcp_serial_port_assertions i_smcp_serial_port_assertions (.clk, .resetn,
    .cs_n, .sdo_out, .sdo_oe_n, .power_state, .clock_timing, .power_down_field,
    .soft_reset_active);
`default_nettype wire

// ---- smcp_serial_port_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
// ****
// bench
// ****
module smcp_serial_port_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic interface_select = 1'b0;
    logic sample_clk = 1'b0;
    logic cs_n, sck, sdi, sdo_out, sdo_oe_n, osc, sra;
    smcp_pkg::smcp_power_s power_state;
    smcp_pkg::smcp_timing_s clock_timing;
    logic [1:0] power_down_field;
    logic [7:0] rd;
    int failures = 0;
    int checks = 0;
    wire sdo_line = sdo_oe_n ? 1'b1 : sdo_out;
    always #5 clk = ~clk;
    logic [1:0] smp_div = 2'h0;
    always @(posedge clk) begin
        smp_div <= smp_div + 2'h1;
        if (smp_div == 2'h3) begin
            sample_clk <= ~sample_clk;
        end
    end
    smcp_serial_port i_smcp_serial_port (.clk(clk), .resetn(resetn),
        .interface_select(interface_select), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_in(sdo_line), .sdo_out(sdo_out), .sdo_oe_n(sdo_oe_n), .sample_clk(sample_clk),
        .power_state(power_state), .clock_timing(clock_timing),
        .power_down_field(power_down_field), .output_sample_clock(osc),
        .soft_reset_active(sra));
    smcp_host_model i_smcp_host_model (.clk(clk), .sdo_line(sdo_line), .cs_n(cs_n),
        .sck(sck), .sdi(sdi));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        i_smcp_host_model.xfer({1'b0, a, d}, 16, rd);
    endtask : wr
    task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
        i_smcp_host_model.xfer({1'b1, a, 8'hff}, 16, rd);
        chk("readback", exp, rd);
    endtask : rdchk
    task automatic t_soft_reset();
        wr(7'h00, 8'h80);
        wr(7'h01, 8'h02);
        wr(7'h02, 8'h05);
        chk("timing", 8'h05, {4'h0, clock_timing});
        wr(7'h00, 8'h80);
        chk("timing", 8'h00, {4'h0, clock_timing});
        chk("pd field", 8'h00, {6'h00, power_down_field});
        rdchk(7'h02, 8'h00);
        wr(7'h02, 8'h01);
        chk("timing", 8'h01, {4'h0, clock_timing});
        $display("test soft_reset done");
    endtask : t_soft_reset
    task automatic t_power_codes();
        for (int c = 0; c < 4; c++) begin
            wr(7'h01, {6'h3f, c[1:0]});
            chk("pd field", {6'h00, c[1:0]}, {6'h00, power_down_field});
            chk("sleep", {7'h00, c == 3}, {7'h00, power_state.sleep});
            rdchk(7'h01, {6'h00, c[1:0]});
        end
        $display("test power_codes done");
    endtask : t_power_codes
    task automatic t_timing();
        wr(7'h02, 8'hfb);
        chk("timing", 8'h0b, {4'h0, clock_timing});
        rdchk(7'h02, 8'h0b);
        rdchk(7'h02, 8'h0b);
        $display("test timing done");
    endtask : t_timing
    task automatic lag(input logic fall, output logic [7:0] n);
        logic prev;
        if (fall) begin
            @(negedge sample_clk);
        end else begin
            @(posedge sample_clk);
        end
        @(posedge clk);
        n = 8'h01;
        prev = osc;
        while (n < 8'h10 && !(osc === 1'b1 && prev === 1'b0)) begin
            prev = osc;
            @(posedge clk);
            n = n + 8'h01;
        end
    endtask : lag
    task automatic t_outclk();
        logic [7:0] base;
        logic [7:0] n;
        wr(7'h02, 8'h01);
        lag(1'b0, base);
        for (int p = 1; p < 4; p++) begin
            wr(7'h02, {5'h00, p[1:0], 1'b1});
            lag(1'b0, n);
            chk("outclk delay", base + 8'(p), n);
        end
        wr(7'h02, 8'h09);
        lag(1'b1, n);
        chk("outclk invert", base, n);
        $display("test outclk done");
    endtask : t_outclk
    task automatic t_framing();
        i_smcp_host_model.xfer({1'b0, 7'h01, 8'h02}, 18, rd);
        chk("pd field", 8'h02, {6'h00, power_down_field});
        i_smcp_host_model.xfer({1'b0, 7'h01, 8'h00}, 12, rd);
        chk("pd field", 8'h02, {6'h00, power_down_field});
        wr(7'h01, 8'h00);
        chk("ch1 valid", 8'h00, {7'h00, power_state.ch1_valid});
        repeat (850) @(posedge clk);
        chk("ch1 valid", 8'h01, {7'h00, power_state.ch1_valid});
        $display("test framing done");
    endtask : t_framing
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        t_soft_reset();
        t_power_codes();
        t_timing();
        t_outclk();
        t_framing();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        report_and_stop();
    end
endmodule : smcp_serial_port_bench
`default_nettype wire
